/* verilog/icrs_pkg.sv */
`default_nettype none
package icrs_pkg;
	localparam logic [7:0] READ_CMD = 8'h15;
	localparam logic DIR_WRITE = 1'h0;
	localparam logic DIR_READ = 1'h1;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_FIRST = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;
	localparam logic BUS_IDLE_LEVEL = 1'h1;
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_ACK = 5'h04,
		ST_TX = 5'h08,
		ST_TXACK = 5'h10
	} icrs_state_t;
endpackage
`default_nettype wire

/* verilog/icrs_slave.sv */
// Functional notes
// - Address byte with direction bit zero means write
// - First byte after address selects target register, unless it equals READ_CMD
// - Data byte committed on acknowledge clock rise
// - Read address byte selects register to return
// - Selected register contents shifted out on data
// - Address byte arrives MSB first, direction last
// - Acknowledge driven low after every received byte, except an address byte that does not match DEV_ADDR and the bytes after it until the next start
// - Master NACK ends read, data line released
`timescale 1ns/100ps
`default_nettype none
module icrs_slave import icrs_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	output logic cfgWrStb,
	output logic [ADDR_W-1:0] cfgWrAddr,
	output logic [7:0] cfgWrData
);
	localparam int REG_COUNT = 1 << ADDR_W;

	typedef struct packed {
		logic sclMeta;
		logic sclSync;
		logic sclPrev;
		logic sdaMeta;
		logic sdaSync;
		logic sdaPrev;
		icrs_state_t st;
		logic [3:0] bitCnt;
		logic [1:0] byteCnt;
		logic [7:0] shiftReg;
		logic [7:0] txShift;
		logic rw;
		logic expectRa;
		logic [ADDR_W-1:0] regPtr;
		logic [ADDR_W-1:0] readPtr;
		logic gotAck;
		logic sdaOe;
		logic wrStb;
		logic [ADDR_W-1:0] wrAddr;
		logic [7:0] wrData;
		logic [REG_COUNT-1:0][7:0] regs;
	} icrs_regs_t;

	icrs_regs_t s;
	icrs_regs_t next_s;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	function automatic logic [ADDR_W-1:0] incPtr(input logic [ADDR_W-1:0] p);
		incPtr = p + {{(ADDR_W-1){1'h0}}, 1'h1};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus conditions, seen only through the second synchroniser stage
	assign sclRise = s.sclSync & ~s.sclPrev;
	assign sclFall = ~s.sclSync & s.sclPrev;
	assign startCond = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
	assign stopCond = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;

	always_comb begin
		next_s = s;
		next_s.sclMeta = sclIn;
		next_s.sclSync = s.sclMeta;
		next_s.sclPrev = s.sclSync;
		next_s.sdaMeta = sdaIn;
		next_s.sdaSync = s.sdaMeta;
		next_s.sdaPrev = s.sdaSync;
		next_s.wrStb = 1'h0;
		if (startCond) begin
			// Repeated start keeps the read pointer set by the write phase
			next_s.st = ST_RX;
			next_s.bitCnt = BIT_FIRST;
			next_s.byteCnt = BYTE_ADDR;
			next_s.sdaOe = 1'h0;
			next_s.gotAck = 1'h0;
		end else if (stopCond) begin
			next_s.st = ST_IDLE;
			next_s.sdaOe = 1'h0;
		end else begin
			case (s.st)
				ST_IDLE: begin
					next_s.sdaOe = 1'h0;
				end
				ST_RX: begin
					if (sclRise) begin
						next_s.shiftReg = {s.shiftReg[6:0], s.sdaSync};
						next_s.bitCnt = s.bitCnt + 4'h1;
					end else if (sclFall && s.bitCnt == BIT_LAST) begin
						if (s.byteCnt == BYTE_ADDR &&
							s.shiftReg[7:1] != DEV_ADDR) begin
							next_s.st = ST_IDLE;
						end else begin
							next_s.st = ST_ACK;
							next_s.sdaOe = 1'h1;
							if (s.byteCnt == BYTE_ADDR) begin
								next_s.rw = s.shiftReg[0];
							end
						end
					end
				end
				ST_ACK: begin
					if (sclRise) begin
						if (s.byteCnt != BYTE_DATA) begin
							next_s.byteCnt = s.byteCnt + 2'h1;
						end
						if (s.rw == DIR_WRITE && s.byteCnt == BYTE_FIRST) begin
							if (s.shiftReg == READ_CMD) begin
								next_s.expectRa = 1'h1;
							end else begin
								next_s.regPtr = s.shiftReg[ADDR_W-1:0];
								next_s.expectRa = 1'h0;
							end
						end
						if (s.rw == DIR_WRITE && s.byteCnt == BYTE_DATA) begin
							if (s.expectRa) begin
								next_s.readPtr = s.shiftReg[ADDR_W-1:0];
								next_s.expectRa = 1'h0;
							end else begin
								// Commit on the acknowledge rise
								next_s.regs[s.regPtr] = s.shiftReg;
								next_s.wrStb = 1'h1;
								next_s.wrAddr = s.regPtr;
								next_s.wrData = s.shiftReg;
								next_s.regPtr = incPtr(s.regPtr);
							end
						end
					end else if (sclFall) begin
						next_s.bitCnt = BIT_FIRST;
						if (s.rw == DIR_READ) begin
							next_s.st = ST_TX;
							next_s.txShift = s.regs[s.readPtr];
							next_s.sdaOe = ~s.regs[s.readPtr][7];
							next_s.readPtr = incPtr(s.readPtr);
						end else begin
							next_s.st = ST_RX;
							next_s.sdaOe = 1'h0;
						end
					end
				end
				ST_TX: begin
					if (sclRise) begin
						next_s.bitCnt = s.bitCnt + 4'h1;
					end else if (sclFall) begin
						if (s.bitCnt == BIT_LAST) begin
							next_s.st = ST_TXACK;
							next_s.sdaOe = 1'h0;
						end else begin
							next_s.txShift = {s.txShift[6:0], 1'h0};
							next_s.sdaOe = ~s.txShift[6];
						end
					end
				end
				ST_TXACK: begin
					if (sclRise) begin
						if (s.sdaSync) begin
							next_s.st = ST_IDLE;
						end else begin
							next_s.gotAck = 1'h1;
						end
					end else if (sclFall && s.gotAck) begin
						// Master acked: stream the following register
						next_s.gotAck = 1'h0;
						next_s.bitCnt = BIT_FIRST;
						next_s.st = ST_TX;
						next_s.txShift = s.regs[s.readPtr];
						next_s.sdaOe = ~s.regs[s.readPtr][7];
						next_s.readPtr = incPtr(s.readPtr);
					end
				end
				default: begin
					next_s.st = ST_IDLE;
					next_s.sdaOe = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
			s.sclMeta <= BUS_IDLE_LEVEL;
			s.sclSync <= BUS_IDLE_LEVEL;
			s.sclPrev <= BUS_IDLE_LEVEL;
			s.sdaMeta <= BUS_IDLE_LEVEL;
			s.sdaSync <= BUS_IDLE_LEVEL;
			s.sdaPrev <= BUS_IDLE_LEVEL;
			s.st <= ST_IDLE;
			s.regs <= {REG_COUNT{REG_RESET}};
		end else begin
			s <= next_s;
		end
	end

	// Open drain: only ever pulls low, the bench resolves the wire
	assign sdaOut = 1'h0;
	assign sdaOe = s.sdaOe;
	assign cfgWrStb = s.wrStb;
	assign cfgWrAddr = s.wrAddr;
	assign cfgWrData = s.wrData;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_dir_write: assert property (
		(s.st == ST_RX && !startCond && !stopCond && sclFall &&
			s.bitCnt == BIT_LAST && s.byteCnt == BYTE_ADDR &&
			s.shiftReg == {DEV_ADDR, DIR_WRITE})
		|=> (s.st == ST_ACK && s.rw == DIR_WRITE && s.sdaOe))
		else $error("matching write address not accepted");
	a_reg_select: assert property (
		(s.st == ST_ACK && sclRise && s.rw == DIR_WRITE &&
			s.byteCnt == BYTE_FIRST && s.shiftReg != READ_CMD)
		|=> s.regPtr == $past(s.shiftReg[ADDR_W-1:0]))
		else $error("register select byte not taken");
	a_write_commit: assert property (
		(s.st == ST_ACK && sclRise && s.rw == DIR_WRITE &&
			s.byteCnt == BYTE_DATA && !s.expectRa)
		|=> (cfgWrStb && cfgWrData == $past(s.shiftReg) &&
			cfgWrAddr == $past(s.regPtr)))
		else $error("data byte not committed on ack rise");
	a_read_select: assert property (
		(s.st == ST_ACK && sclRise && s.rw == DIR_WRITE &&
			s.byteCnt == BYTE_DATA && s.expectRa)
		|=> (s.readPtr == $past(s.shiftReg[ADDR_W-1:0]) && !cfgWrStb))
		else $error("read address not latched");
	a_tx_bit: assert property (
		s.st == ST_TX |-> sdaOe == ~s.txShift[7])
		else $error("transmit bit does not match register data");
	a_msb_first: assert property (
		(s.st == ST_RX && sclRise && !startCond && !stopCond)
		|=> (s.shiftReg[0] == $past(s.sdaSync) &&
			s.shiftReg[7:1] == $past(s.shiftReg[6:0])))
		else $error("received bit not shifted in msb first");
	a_ack_drive: assert property (
		s.st == ST_ACK |-> sdaOe)
		else $error("no acknowledge driven");
	a_nack_release: assert property (
		(s.st == ST_TXACK && sclRise && s.sdaSync && !stopCond &&
			!startCond)
		|=> (s.st == ST_IDLE && !sdaOe) [*2])
		else $error("data line not released after nack");
	a_foreign_quiet: assert property (
		(s.st == ST_RX && sclFall && s.bitCnt == BIT_LAST &&
			s.byteCnt == BYTE_ADDR && s.shiftReg[7:1] != DEV_ADDR &&
			!startCond && !stopCond)
		|=> (s.st == ST_IDLE && !sdaOe))
		else $error("foreign address acknowledged");
endmodule // icrs_slave
`default_nettype wire

/* dv/icrs_master.sv */
`timescale 1ns/100ps
`default_nettype none
module icrs_master (
	input wire logic clk,
	input wire logic sdaWire,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'h1;
		sda = 1'h1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////
	// Data only moves mid-low so no false start or stop is seen
	task automatic bit_cyc(input logic b, output logic s);
		tick(2);
		sda = b;
		tick(2);
		scl = 1'h1;
		tick(2);
		s = sdaWire;
		tick(2);
		scl = 1'h0;
	endtask
	// Long first wait lets the slave let go of data before a restart
	task automatic start();
		sda = 1'h1;
		tick(4);
		scl = 1'h1;
		tick(2);
		sda = 1'h0;
		tick(2);
		scl = 1'h0;
	endtask
	task automatic stop();
		tick(2);
		sda = 1'h0;
		tick(2);
		scl = 1'h1;
		tick(2);
		sda = 1'h1;
		tick(4);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
		bit_cyc(1'h1, s);
		ack = ~s;
	endtask
	task automatic recv_byte(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cyc(1'h1, d[i]);
		bit_cyc(~ackIt, s);
	endtask
endmodule // icrs_master
`default_nettype wire

/* dv/test_i2c_register_command_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module test_i2c_register_command_slave;
	import icrs_pkg::*;
	localparam logic [6:0] DEV_A = 7'h2A; // Arbitrary bus address
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic scl, mSda, sdaOut, sdaOe, cfgWrStb, ack, stbScl;
	logic [7:0] cfgWrAddr, cfgWrData, seenA, seenD, rd;
	int mismatches = 0;
	int cmp_count = 0;
	int stbCnt = 0;
	// Pull-up: the wire is low if either side pulls it
	wire logic sdaWire = mSda & (sdaOe ? sdaOut : 1'h1);
	always #25 clk = ~clk;
	icrs_master master (.clk(clk), .sdaWire(sdaWire), .scl(scl),
		.sda(mSda));
	icrs_slave #(.DEV_ADDR(DEV_A)) DUT (.clk(clk), .sys_rst(sys_rst),
		.sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.cfgWrStb(cfgWrStb), .cfgWrAddr(cfgWrAddr), .cfgWrData(cfgWrData));
	always @(posedge clk) begin
		if (cfgWrStb === 1'h1) begin
			stbCnt++;
			seenA = cfgWrAddr;
			seenD = cfgWrData;
			// Link clock level while the commit strobe stands
			stbScl = scl;
		end
	end
	////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_write();
		int n0;
		n0 = stbCnt;
		master.start();
		master.send_byte({DEV_A, DIR_WRITE}, ack);
		check("addr ack", ack, 1'h1);
		master.send_byte(8'h03, ack);
		check("ptr ack", ack, 1'h1);
		master.send_byte(8'hA5, ack);
		check("data ack", ack, 1'h1);
		master.tick(2);
		check("strobes", 8'(stbCnt - n0), 8'h01);
		check("strobe scl", stbScl, 1'h1);
		check("wr addr", seenA, 8'h03);
		check("wr data", seenD, 8'hA5);
		master.send_byte(8'h5A, ack);
		master.tick(2);
		check("next addr", seenA, 8'h04);
		check("next data", seenD, 8'h5A);
		master.stop();
		$display("write test done");
	endtask
	task automatic t_read();
		master.start();
		master.send_byte({DEV_A, DIR_WRITE}, ack);
		master.send_byte(READ_CMD, ack);
		master.send_byte(8'h03, ack);
		check("raddr ack", ack, 1'h1);
		master.start();
		master.send_byte({DEV_A, DIR_READ}, ack);
		check("rd ack", ack, 1'h1);
		master.recv_byte(1'h1, rd);
		check("rd first", rd, 8'hA5);
		master.recv_byte(1'h0, rd);
		check("rd second", rd, 8'h5A);
		check("oe after nack", sdaOe, 1'h0);
		master.stop();
		$display("read test done");
	endtask
	task automatic t_foreign();
		int n0;
		n0 = stbCnt;
		master.start();
		master.send_byte({DEV_A ^ 7'h01, DIR_WRITE}, ack);
		check("foreign ack", ack, 1'h0);
		master.send_byte(8'h07, ack);
		check("foreign byte ack", ack, 1'h0);
		check("foreign oe", sdaOe, 1'h0);
		master.stop();
		check("foreign strobes", 8'(stbCnt - n0), 8'h00);
		$display("foreign address test done");
	endtask
	////////////////////////////////////////
	initial begin
		#500000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'h0;
		master.tick(6);
		check("oe reset", sdaOe, 1'h0);
		t_write();
		t_read();
		t_foreign();
		give_verdict();
	end
endmodule // test_i2c_register_command_slave
`default_nettype wire
